// ---- lwake_defs.svh ----
// register offsets, field positions and reset values of the wake-up unit
// assumes inclusion by bare name from lwake_pin_det, lwake_top and the testbench
`ifndef LWAKE_DEFS_SVH
`define LWAKE_DEFS_SVH
// ****************************************
// register byte offsets (low address bits)
// ****************************************
`define LWAKE_OFS_EDGE   8'h00
`define LWAKE_OFS_MODEN  8'h04
`define LWAKE_OFS_FILT   8'h08
`define LWAKE_OFS_PFLAG  8'h0C
`define LWAKE_OFS_MFLAG  8'h10
`define LWAKE_OFS_PWR    8'h14
`define LWAKE_OFS_ISTAT  8'h18
`define LWAKE_OFS_IMASK  8'h1C
// ****************************************
// fields and reset values
// ****************************************
`define LWAKE_PWR_ACK    0
`define LWAKE_PWR_HOLD   1
`define LWAKE_PWR_ACT    2
`define LWAKE_IRQ_PIN    0
`define LWAKE_IRQ_MOD    1
`define LWAKE_IRQ_EXIT   2
`define LWAKE_MOD_VALID  8'hB3
`define LWAKE_RST_EDGE   32'h0000_0000
`define LWAKE_RST_MODEN  8'h00
`define LWAKE_RST_FILT   16'h0000
`define LWAKE_RST_IMASK  3'h0
`define LWAKE_FILT_LEN   3
`endif

// ---- lwake_flags.sv ----
// sticky flag bank: set by hardware, cleared by writing one
// assumes set and clear are one-cycle requests on hclk
`timescale 1ns/1ps
module lwake_flags #(
  parameter int W = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags
);
  logic [W-1:0] next_flags;

  // set wins over a clear in the same cycle so no event is lost
  always_comb begin
    next_flags = (flags & ~clr) | set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end
endmodule

// ---- lwake_partner.sv ----
// far-side model: power mode controller, wake pins and module sources
// assumes the bench steers it through the cmd inputs on hclk
`timescale 1ns/1ps
module lwake_partner (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   go,
  input  wire lwake_pkg::lwake_mode_t go_mode,
  input  wire logic [31:0]            lag,
  input  wire logic [15:0]            pin_cmd,
  input  wire logic [7:0]             mod_cmd,
  input  wire logic                   nmi_cmd,
  input  wire logic                   rst_cmd,
  input  wire logic                   exit_interrupt,
  input  wire logic                   exit_reset,
  output lwake_pkg::lwake_mode_t      power_mode,
  output logic      [15:0]            wake_pin_in,
  output logic      [7:0]             module_wake_in,
  output logic                        nmi_pin,
  output logic                        reset_pin
);
  logic [31:0] wait_cnt;
  // a large lag keeps the chip asleep so several events can be seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_mode     <= lwake_pkg::LWAKE_RUN;
      wake_pin_in    <= 16'h0000;
      module_wake_in <= 8'h00;
      nmi_pin        <= 1'b0;
      reset_pin      <= 1'b0;
      wait_cnt       <= 32'h0000_0000;
    end else begin
      wake_pin_in    <= pin_cmd;
      module_wake_in <= mod_cmd;
      nmi_pin        <= nmi_cmd;
      reset_pin      <= rst_cmd;
      if (go) begin
        power_mode <= go_mode;
        wait_cnt   <= 32'h0000_0000;
      end else if (power_mode != lwake_pkg::LWAKE_RUN &&
                   (exit_interrupt || exit_reset)) begin
        if (wait_cnt >= lag) begin
          power_mode <= lwake_pkg::LWAKE_RUN;
        end else begin
          wait_cnt <= wait_cnt + 32'h0000_0001;
        end
      end
    end
  end
endmodule

// ---- lwake_pin_det.sv ----
// one wake pin: optional digital filter and edge detector
// assumes the pin is synchronous to hclk
`timescale 1ns/1ps
`include "lwake_defs.svh"
module lwake_pin_det #(
  parameter int FILT_LEN = `LWAKE_FILT_LEN
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       pin,
  input  wire logic       active,
  input  wire logic [1:0] edge_sel,
  input  wire logic       filt_on,
  output logic            hit
);
  lwake_pkg::lwake_pin_t st;
  lwake_pkg::lwake_pin_t next_st;
  logic                  level;

  // filter needs FILT_LEN stable cycles before the level moves
  assign level = filt_on ? st.filt_val : pin;
  // edge_sel: 01 rising, 10 falling, 11 either, 00 disabled
  assign hit = active & ((edge_sel[0] & level & ~st.prev) |
                         (edge_sel[1] & ~level & st.prev));

  always_comb begin
    next_st = st;
    next_st.prev = level;
    if (pin != st.filt_val) begin
      if (st.filt_cnt == 4'(FILT_LEN - 1)) begin
        next_st.filt_val = pin;
        next_st.filt_cnt = 4'h0;
      end else begin
        next_st.filt_cnt = st.filt_cnt + 4'h1;
      end
    end else begin
      next_st.filt_cnt = 4'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ---- lwake_pkg.sv ----
// types shared by the wake-up unit modules
// assumes lwake_defs.svh is on the include path
package lwake_pkg;
  typedef enum logic [2:0] {
    LWAKE_RUN,
    LWAKE_LLS,
    LWAKE_RAM_RETAINING_LEAKAGE_STOP,
    LWAKE_VLLS1,
    LWAKE_DEEPEST_LEAKAGE_STOP
  } lwake_mode_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } lwake_ahb_req_t;

  typedef struct packed {
    logic [31:0] edge_sel;
    logic [7:0]  mod_en;
    logic [15:0] filt_en;
    logic [2:0]  irq_mask;
    logic        io_hold;
    logic        dph_wr;
    logic [7:0]  dph_ofs;
    logic [31:0] rdata;
  } lwake_state_t;

  typedef struct packed {
    logic        filt_val;
    logic [3:0]  filt_cnt;
    logic        prev;
  } lwake_pin_t;
endpackage

// ---- lwake_top.sv ----
// low-leakage wake-up unit with AHB-Lite register slave
// assumes power_mode comes from the power mode controller on hclk
//
// How it works
// - detection runs while the chip sits in a low-leakage stop mode or while io_hold is set.
// - on leaving the shallow leakage stop the unit goes static at once.
// - after a very-low-leakage recovery detection goes on until ack.
// - sixteen pins and eight module inputs each have their own enable.
// - each pin triggers on falling, rising or either edge.
// - an input counts only when enabled and in a low-leakage mode or under io_hold.
// - pin filters are optional and bypassed in the deepest stop.
// - a wake from the shallow leakage stop exits through an interrupt.
// - module inputs 0,1,4,5,7 are used and 2,3,6 are reserved.
// - a pin flag clears on a written one and ignores a written zero.
// - stop modes exit only on a wake, the nmi pin or the reset pin.
// - any exit from a very-low-leakage stop goes through reset.
// - pins stay latched after such recovery until software releases.
// - RAM is kept in run, the shallow leakage stop and the ram-retaining very-low-leakage stop.
`timescale 1ns/1ps
`include "lwake_defs.svh"
module lwake_top #(
  parameter int NPIN     = 16,
  parameter int NMOD     = 8,
  parameter int FILT_LEN = `LWAKE_FILT_LEN
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  input  wire logic [31:0]            hwdata,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire lwake_pkg::lwake_mode_t power_mode,
  input  wire logic [NPIN-1:0]        wake_pin_in,
  input  wire logic [NMOD-1:0]        module_wake_in,
  input  wire logic                   nmi_pin,
  input  wire logic                   reset_pin,
  output logic                        exit_interrupt,
  output logic                        exit_reset,
  output logic                        io_hold,
  output logic                        ram_retain,
  output logic                        irq
);
  // ****************************************
  // state and bus decode
  // ****************************************
  lwake_pkg::lwake_ahb_req_t req;
  lwake_pkg::lwake_state_t   st;
  lwake_pkg::lwake_state_t   next_st;
  logic            in_lls;
  logic            in_very_low_leakage_stop_mode;
  logic            in_stop;
  logic            det_active;
  logic            addr_ok;
  logic            aph;
  logic            wr_now;
  logic            ack_wr;
  logic [NPIN-1:0] pin_hit;
  logic [NPIN-1:0] pin_clr;
  logic [NPIN-1:0] pin_flag;
  logic [NPIN-1:0] filt_eff;
  logic [NMOD-1:0] mod_set;
  logic [NMOD-1:0] mod_clr;
  logic [NMOD-1:0] mod_flag;
  logic [2:0]      irq_set;
  logic [2:0]      irq_clr;
  logic [2:0]      irq_stat;
  logic            wake_any;

  assign req = '{hsel, haddr, htrans, hwrite, hsize, hready, hwdata};
  // zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st.rdata;
  assign aph       = req.hsel & req.htrans[1] & req.hready;
  assign addr_ok   = (req.haddr[31:8] == 24'h00_0000) &
                     (req.haddr[1:0] == 2'b00);
  assign wr_now    = st.dph_wr;

  // ****************************************
  // power mode view
  // ****************************************
  assign in_lls  = (power_mode == lwake_pkg::LWAKE_LLS);
  assign in_very_low_leakage_stop_mode = (power_mode == lwake_pkg::LWAKE_RAM_RETAINING_LEAKAGE_STOP) |
                   (power_mode == lwake_pkg::LWAKE_VLLS1) |
                   (power_mode == lwake_pkg::LWAKE_DEEPEST_LEAKAGE_STOP);
  assign in_stop = in_lls | in_very_low_leakage_stop_mode;
  // after a shallow stop nothing keeps it alive, after a deep one the
  // hold does
  assign det_active = in_stop | st.io_hold;
  assign io_hold    = st.io_hold;
  assign ram_retain = ~((power_mode == lwake_pkg::LWAKE_VLLS1) |
                        (power_mode == lwake_pkg::LWAKE_DEEPEST_LEAKAGE_STOP));
  assign ack_wr = wr_now & (st.dph_ofs == `LWAKE_OFS_PWR) &
                  req.hwdata[`LWAKE_PWR_ACK];

  // ****************************************
  // wake sources
  // ****************************************
  // filters drop out in the deepest stop where their clock is gone
  assign filt_eff = (power_mode == lwake_pkg::LWAKE_DEEPEST_LEAKAGE_STOP) ?
                    '0 : st.filt_en;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      lwake_pin_det #(
        .FILT_LEN (FILT_LEN)
      ) u_pin (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .pin      (wake_pin_in[gi]),
        .active   (det_active),
        .edge_sel (st.edge_sel[2*gi +: 2]),
        .filt_on  (filt_eff[gi]),
        .hit      (pin_hit[gi])
      );
    end
  endgenerate

  assign mod_set = module_wake_in & st.mod_en &
                   {NMOD{det_active}};
  assign pin_clr = (wr_now & (st.dph_ofs == `LWAKE_OFS_PFLAG)) ?
                   req.hwdata[NPIN-1:0] : '0;
  assign mod_clr = (wr_now & (st.dph_ofs == `LWAKE_OFS_MFLAG)) ?
                   req.hwdata[NMOD-1:0] : '0;

  lwake_flags #(
    .W (NPIN)
  ) u_pin_flags (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (pin_hit),
    .clr     (pin_clr),
    .flags   (pin_flag)
  );

  lwake_flags #(
    .W (NMOD)
  ) u_mod_flags (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (mod_set),
    .clr     (mod_clr),
    .flags   (mod_flag)
  );

  // ****************************************
  // exit paths
  // ****************************************
  assign wake_any = (|pin_flag) | (|mod_flag);
  assign exit_interrupt = in_lls & ~reset_pin &
                          (wake_any | nmi_pin);
  assign exit_reset = (in_lls & reset_pin) |
                      (in_very_low_leakage_stop_mode & (wake_any | nmi_pin |
                                  reset_pin));

  // ****************************************
  // interrupt status and mask
  // ****************************************
  assign irq_set = {exit_interrupt | exit_reset, |mod_set, |pin_hit};
  assign irq_clr = (wr_now & (st.dph_ofs == `LWAKE_OFS_ISTAT)) ?
                   req.hwdata[2:0] : 3'h0;

  lwake_flags #(
    .W (3)
  ) u_irq_flags (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (irq_set),
    .clr     (irq_clr),
    .flags   (irq_stat)
  );

  assign irq = |(irq_stat & st.irq_mask);

  // ****************************************
  // register file
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.dph_wr = aph & req.hwrite & addr_ok;
    if (aph) begin
      next_st.dph_ofs = req.haddr[7:0];
    end
    // hold is taken on deep entry, dropped only by the ack write
    if (in_very_low_leakage_stop_mode) begin
      next_st.io_hold = 1'b1;
    end else if (ack_wr) begin
      next_st.io_hold = 1'b0;
    end
    if (wr_now) begin
      if (st.dph_ofs == `LWAKE_OFS_EDGE) begin
        next_st.edge_sel = req.hwdata;
      end else if (st.dph_ofs == `LWAKE_OFS_MODEN) begin
        next_st.mod_en = req.hwdata[7:0] & `LWAKE_MOD_VALID;
      end else if (st.dph_ofs == `LWAKE_OFS_FILT) begin
        next_st.filt_en = req.hwdata[15:0];
      end else if (st.dph_ofs == `LWAKE_OFS_IMASK) begin
        next_st.irq_mask = req.hwdata[2:0];
      end
    end
    // read data is fetched in the address phase; a read right after a
    // write to the same word sees the old value
    next_st.rdata = 32'h0000_0000;
    if (aph & ~req.hwrite & addr_ok) begin
      if (req.haddr[7:0] == `LWAKE_OFS_EDGE) begin
        next_st.rdata = st.edge_sel;
      end else if (req.haddr[7:0] == `LWAKE_OFS_MODEN) begin
        next_st.rdata = {24'h00_0000, st.mod_en};
      end else if (req.haddr[7:0] == `LWAKE_OFS_FILT) begin
        next_st.rdata = {16'h0000, st.filt_en};
      end else if (req.haddr[7:0] == `LWAKE_OFS_PFLAG) begin
        next_st.rdata = {16'h0000, pin_flag};
      end else if (req.haddr[7:0] == `LWAKE_OFS_MFLAG) begin
        next_st.rdata = {24'h00_0000, mod_flag};
      end else if (req.haddr[7:0] == `LWAKE_OFS_PWR) begin
        next_st.rdata[`LWAKE_PWR_HOLD] = st.io_hold;
        next_st.rdata[`LWAKE_PWR_ACT]  = det_active;
      end else if (req.haddr[7:0] == `LWAKE_OFS_ISTAT) begin
        next_st.rdata = {29'h0000_0000, irq_stat};
      end else if (req.haddr[7:0] == `LWAKE_OFS_IMASK) begin
        next_st.rdata = {29'h0000_0000, st.irq_mask};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st          <= '0;
      st.edge_sel <= `LWAKE_RST_EDGE;
      st.mod_en   <= `LWAKE_RST_MODEN;
      st.filt_en  <= `LWAKE_RST_FILT;
      st.irq_mask <= `LWAKE_RST_IMASK;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  idle_no_flag_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !det_active |=> ((pin_flag & ~$past(pin_flag)) == '0))
    else $error("pin flag set while unit inactive");

  shallow_static_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (power_mode == lwake_pkg::LWAKE_RUN) && !st.io_hold |-> !det_active)
    else $error("unit active after shallow recovery");

  hold_until_ack_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st.io_hold && !ack_wr |=> st.io_hold)
    else $error("hold dropped without ack");

  deep_sets_hold_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    in_very_low_leakage_stop_mode |=> io_hold)
    else $error("pins not held after deep stop");

  mod_gated_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ((mod_flag & ~$past(mod_flag)) != '0) |->
      $past(det_active) && (($past(st.mod_en) & mod_flag) != '0))
    else $error("module flag set without enable or activity");

  filt_bypass_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (power_mode == lwake_pkg::LWAKE_DEEPEST_LEAKAGE_STOP) |-> (filt_eff == '0))
    else $error("filter active in deepest stop");

  shallow_irq_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    in_lls && wake_any && !reset_pin |-> exit_interrupt && !exit_reset)
    else $error("shallow wake did not take interrupt path");

  reserved_off_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st.mod_en & ~`LWAKE_MOD_VALID) == 8'h00)
    else $error("reserved module input enabled");

  flag_keep_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (pin_clr == '0) |=> ((pin_flag & $past(pin_flag)) == $past(pin_flag)))
    else $error("pin flag lost without a written one");

  run_no_exit_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !in_stop |-> !exit_interrupt && !exit_reset)
    else $error("exit raised outside stop modes");

  deep_via_reset_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    in_very_low_leakage_stop_mode && (wake_any || nmi_pin) |-> exit_reset && !exit_interrupt)
    else $error("deep exit not through reset");

  ram_keep_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ram_retain == !(power_mode == lwake_pkg::LWAKE_VLLS1 ||
                    power_mode == lwake_pkg::LWAKE_DEEPEST_LEAKAGE_STOP))
    else $error("ram retention wrong for mode");

  hit_sets_flag_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (pin_hit != '0) |=> ((pin_flag & $past(pin_hit)) == $past(pin_hit)))
    else $error("pin event did not set its flag");
endmodule

// ---- testbench.sv ----
// self-checking bench for the wake-up unit
// assumes lwake_pkg, lwake_top and lwake_partner are compiled first
`timescale 1ns/1ps
`include "lwake_defs.svh"
module testbench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        go = 1'b0;
  lwake_pkg::lwake_mode_t go_mode = lwake_pkg::LWAKE_RUN;
  lwake_pkg::lwake_mode_t power_mode;
  lwake_pkg::lwake_mode_t ml [4] = '{lwake_pkg::LWAKE_LLS,
    lwake_pkg::LWAKE_RAM_RETAINING_LEAKAGE_STOP, lwake_pkg::LWAKE_VLLS1, lwake_pkg::LWAKE_DEEPEST_LEAKAGE_STOP};
  logic [31:0] lag = 32'h0000_03E8;
  logic [15:0] pin_cmd = 16'h0000;
  logic [15:0] wake_pin_in;
  logic [7:0]  mod_cmd = 8'h00;
  logic [7:0]  module_wake_in;
  logic        nmi_cmd = 1'b0;
  logic        rst_cmd = 1'b0;
  logic        nmi_pin;
  logic        reset_pin;
  logic        exit_interrupt;
  logic        exit_reset;
  logic        io_hold;
  logic        ram_retain;
  logic        irq;
  logic        rd_dp = 1'b0;
  logic [31:0] exp_q [$];
  logic [31:0] r;
  int          bad_count = 0;
  int          cmp_count = 0;

  lwake_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .power_mode(power_mode),
    .wake_pin_in(wake_pin_in), .module_wake_in(module_wake_in),
    .nmi_pin(nmi_pin), .reset_pin(reset_pin),
    .exit_interrupt(exit_interrupt), .exit_reset(exit_reset),
    .io_hold(io_hold), .ram_retain(ram_retain), .irq(irq));
  lwake_partner i_far (.hclk(hclk), .hresetn(hresetn), .go(go),
    .go_mode(go_mode), .lag(lag), .pin_cmd(pin_cmd), .mod_cmd(mod_cmd),
    .nmi_cmd(nmi_cmd), .rst_cmd(rst_cmd), .exit_interrupt(exit_interrupt),
    .exit_reset(exit_reset), .power_mode(power_mode),
    .wake_pin_in(wake_pin_in), .module_wake_in(module_wake_in),
    .nmi_pin(nmi_pin), .reset_pin(reset_pin));

  always #10 hclk = ~hclk;

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp  <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp  <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
    @(negedge hclk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ahb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic mode(input lwake_pkg::lwake_mode_t m);
    @(posedge hclk);
    go      <= 1'b1;
    go_mode <= m;
    @(posedge hclk);
    go      <= 1'b0;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
  endtask
  task automatic pins(input logic [15:0] p, input int n);
    @(posedge hclk);
    pin_cmd <= p;
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask
  // a rise on pin 0 after a low spell; tells whether detection is live
  task automatic probe(input logic [31:0] e);
    wr(`LWAKE_OFS_PFLAG, 32'h0000_FFFF);
    pins(16'h0000, 3);
    pins(16'h0001, 3);
    rd(`LWAKE_OFS_PFLAG, e);
  endtask

  // read data is judged at mid data phase, once hrdata has settled
  always @(negedge hclk) begin
    if (rd_dp) begin
      check(hrdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    test_done();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    r = $urandom(32'h017dd447);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check(io_hold, 1'b0);
    check(irq, 1'b0);
    check(ram_retain, 1'b1);
    check(hresp, 1'b0);
    wr(32'h0000_0100, 32'hFFFF_FFFF);
    rd(`LWAKE_OFS_EDGE, `LWAKE_RST_EDGE);
    rd(`LWAKE_OFS_FILT, 32'h0000_0000);
    rd(`LWAKE_OFS_PWR, 32'h0000_0000);
    rd(32'h0000_0020, 32'h0000_0000);
    wr(`LWAKE_OFS_EDGE, 32'h0000_0139);
    wr(`LWAKE_OFS_FILT, 32'h0000_0010);
    wr(`LWAKE_OFS_IMASK, 32'h0000_0001);
    r = $urandom();
    wr(`LWAKE_OFS_MODEN, r);
    rd(`LWAKE_OFS_MODEN, r & 32'h0000_00B3);
    pins(16'h000F, 3);
    pins(16'h0000, 3);
    mod_cmd <= r[15:8];
    rd(`LWAKE_OFS_PFLAG, 32'h0000_0000);
    rd(`LWAKE_OFS_MFLAG, 32'h0000_0000);
    mode(lwake_pkg::LWAKE_LLS);
    rd(`LWAKE_OFS_MFLAG, {24'h00_0000, r[7:0] & r[15:8] & 8'hB3});
    mod_cmd <= 8'h00;
    pins(16'h000F, 3);
    check(exit_interrupt, 1'b1);
    check(exit_reset, 1'b0);
    check(irq, 1'b1);
    wr(`LWAKE_OFS_IMASK, 32'h0000_0000);
    check(irq, 1'b0);
    wr(`LWAKE_OFS_IMASK, 32'h0000_0001);
    check(irq, 1'b1);
    wr(`LWAKE_OFS_ISTAT, 32'h0000_0007);
    check(irq, 1'b0);
    pins(16'h0000, 3);
    rd(`LWAKE_OFS_PFLAG, 32'h0000_0007);
    wr(`LWAKE_OFS_PFLAG, 32'h0000_0000);
    rd(`LWAKE_OFS_PFLAG, 32'h0000_0007);
    wr(`LWAKE_OFS_PFLAG, 32'h0000_0005);
    rd(`LWAKE_OFS_PFLAG, 32'h0000_0002);
    // pins(p, n) holds p for n+1 cycles: a two-cycle pulse is below
    // the three-cycle filter and must be dropped
    pins(16'h0010, 1);
    pins(16'h0000, 4);
    wr(`LWAKE_OFS_PFLAG, 32'h0000_0002);
    rd(`LWAKE_OFS_PFLAG, 32'h0000_0000);
    pins(16'h0010, 6);
    pins(16'h0000, 6);
    rd(`LWAKE_OFS_PFLAG, 32'h0000_0010);
    wr(`LWAKE_OFS_PFLAG, 32'h0000_FFFF);
    wr(`LWAKE_OFS_MFLAG, 32'h0000_00FF);
    nmi_cmd <= 1'b1;
    repeat (2) @(negedge hclk);
    check(exit_interrupt, 1'b1);
    nmi_cmd <= 1'b0;
    rst_cmd <= 1'b1;
    repeat (2) @(negedge hclk);
    check(exit_reset, 1'b1);
    check(exit_interrupt, 1'b0);
    rst_cmd <= 1'b0;
    foreach (ml[i]) begin
      mode(ml[i]);
      check(ram_retain, !(ml[i] inside {lwake_pkg::LWAKE_VLLS1,
                                        lwake_pkg::LWAKE_DEEPEST_LEAKAGE_STOP}));
    end
    pins(16'h0010, 1);
    pins(16'h0000, 3);
    check(exit_reset, 1'b1);
    check(exit_interrupt, 1'b0);
    rd(`LWAKE_OFS_PFLAG, 32'h0000_0010);
    lag <= 32'h0000_0003;
    repeat (10) @(negedge hclk);
    check(io_hold, 1'b1);
    rd(`LWAKE_OFS_PWR, 32'h0000_0006);
    probe(32'h0000_0001);
    wr(`LWAKE_OFS_PWR, 32'h0000_0001);
    check(io_hold, 1'b0);
    probe(32'h0000_0000);
    mode(lwake_pkg::LWAKE_LLS);
    probe(32'h0000_0001);
    repeat (10) @(negedge hclk);
    check(io_hold, 1'b0);
    probe(32'h0000_0000);
    test_done();
  end
endmodule
